/* uartrs_pkg.sv */
package uartrs_pkg;

	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_DATA      = 4'h0;
	localparam logic [3:0] IDX_IER       = 4'h1;
	localparam logic [3:0] IDX_IIR_FCR   = 4'h2;
	localparam logic [3:0] IDX_LCR       = 4'h3;
	localparam logic [3:0] IDX_MCR       = 4'h4;
	localparam logic [3:0] IDX_LSR       = 4'h5;
	localparam logic [3:0] IDX_MSR       = 4'h6;
	localparam logic [3:0] IDX_SPR       = 4'h7;
	localparam logic [3:0] IDX_TX_FIFO_FILL_REG     = 4'h8;
	localparam logic [3:0] IDX_RX_FIFO_FILL_REG     = 4'h9;
	localparam logic [3:0] IDX_GPIO_DIR  = 4'hA;
	localparam logic [3:0] IDX_GPIO_ST   = 4'hB;
	localparam logic [3:0] IDX_GPIO_IRQ  = 4'hC;
	localparam logic [3:0] IDX_GPIO_CTL  = 4'hE;
	localparam logic [3:0] IDX_EXTRA     = 4'hF;

	// field positions and codes
	localparam int         LCR_DL_BIT    = 7;
	localparam int         MCR_PRESC_BIT = 7;
	localparam int         MCR_TCR_BIT   = 2;
	localparam int         EFR_ENH_BIT   = 4;
	localparam logic [7:0] LCR_SPECIAL   = 8'hBF;

	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic       GPIO_PRESENT  = 1'b1;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	// divisors for a 3.072 MHz reference, 16x sampling
	localparam logic [15:0] DIV_9600     = 16'h0014;
	localparam logic [15:0] DIV_19200    = 16'h000A;
	localparam logic [15:0] DIV_38400    = 16'h0005;

	typedef enum logic [4:0] {
		SL_IER      = 5'h00,
		SL_LCR      = 5'h01,
		SL_MCR      = 5'h02,
		SL_SPR      = 5'h03,
		SL_TCR      = 5'h04,
		SL_TLR      = 5'h05,
		SL_GPIO_DIR = 5'h06,
		SL_GPIO_IRQ = 5'h07,
		SL_GPIO_CTL = 5'h08,
		SL_EXTRA    = 5'h09,
		SL_DIV_LO   = 5'h0A,
		SL_DIV_HI   = 5'h0B,
		SL_EFR      = 5'h0C,
		SL_RES1     = 5'h0D,
		SL_RES2     = 5'h0E,
		SL_PAU1     = 5'h0F,
		SL_PAU2     = 5'h10
	} uartrs_slot_t;

	localparam int NUM_SLOTS = 17;

	typedef enum logic [3:0] {
		K_NONE   = 4'h0,
		K_STORE  = 4'h1,
		K_RHR    = 4'h2,
		K_THR    = 4'h3,
		K_IIR    = 4'h4,
		K_FCR    = 4'h5,
		K_LSR    = 4'h6,
		K_MSR    = 4'h7,
		K_TX_FIFO_FILL_REG  = 4'h8,
		K_RX_FIFO_FILL_REG  = 4'h9,
		K_GPIO   = 4'hA
	} uartrs_kind_t;

	typedef struct packed {
		uartrs_kind_t kind;
		uartrs_slot_t slot;
	} uartrs_sel_t;

	typedef struct packed {
		logic [7:0] rx_holding;
		logic [7:0] irq_ident;
		logic [7:0] line_status;
		logic [7:0] modem_status;
		logic [7:0] tx_fill;
		logic [7:0] rx_fill;
	} uartrs_stat_t;

	typedef struct packed {
		logic [7:0]  irq_enable;
		logic [7:0]  line_control;
		logic [7:0]  modem_control;
		logic [7:0]  scratch;
		logic [7:0]  flow_halt_resume;
		logic [7:0]  trigger_level;
		logic [7:0]  gpio_direction;
		logic [7:0]  gpio_irq_enable;
		logic [7:0]  gpio_control;
		logic [7:0]  extra_features;
		logic [15:0] divisor;
		logic [7:0]  enhanced_feature;
		logic [7:0]  resume_char_one;
		logic [7:0]  resume_char_two;
		logic [7:0]  pause_char_one;
		logic [7:0]  pause_char_two;
	} uartrs_cfg_t;

endpackage

/* uartrs_byte_reg.sv */
`timescale 1ns/1ps
module uartrs_byte_reg #(
	parameter logic [7:0] RESET_VAL = uartrs_pkg::RST_BYTE
) (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] value_reg
);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			value_reg <= RESET_VAL;
		end else if (wr_en) begin
			value_reg <= wr_data;
		end
	end
endmodule

/* uartrs_regsel.sv */
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: data index reads receive holding byte, writes transmit holding byte, separate storage.
// RULE_02: index two reads interrupt identification, writes go to FIFO control.
// RULE_03: interrupt enable and line control are read/write, reads return last write.
// RULE_04: line status, modem status, both FIFO fill levels are read only.
// RULE_05: GPIO pin state is read only, present only on GPIO variants.
// RULE_06: scratch, GPIO direction/irq/control, extra features are read/write.
// RULE_07: prescaler bit of modem control writable only while enhanced bit set.
// RULE_08: halt/resume and trigger level reachable only with enhanced bit and modem bit 2.
// RULE_09: divisor bytes reachable only while line control bit 7 is one.
// RULE_10: enhanced feature and flow characters reachable only while line control is BF.
// RULE_11: host programs divisor 20, 10, 5 for 9600, 19200, 38400 at 3.072 MHz.
// RULE_12: enhanced feature bit 4 unlocks the extended registers.
// RULE_13: low divisor byte is LSB, high divisor byte MSB, of 16-bit divisor.
// RULE_14: writes to read-only or locked registers are ignored, no state changes.
module uartrs_regsel (
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire uartrs_pkg::uartrs_stat_t uart_status,
	input  wire logic [7:0]              gpio_pins,
	output uartrs_pkg::uartrs_cfg_t      uart_config,
	output logic [7:0]                   tx_data_reg,
	output logic                         tx_load_reg,
	output logic [7:0]                   fifo_ctrl_data_reg,
	output logic                         fifo_ctrl_load_reg,
	output logic                         rx_pop_reg,
	output logic                         irq_ident_read_reg
);
	logic [7:0]  store_q [uartrs_pkg::NUM_SLOTS];
	logic [7:0]  aw_addr_reg;
	logic [7:0]  wdata_reg;
	logic        wstrb0_reg;
	logic [7:0]  gpio_meta_reg;
	logic [7:0]  gpio_sync_reg;
	logic        wr_do;
	logic        wr_unmapped;
	logic        rd_take;
	logic        rd_unmapped;
	logic        lcr_dl;
	logic        lcr_bf;
	logic        enh_on;
	logic        tcr_on;
	logic [7:0]  mcr_wr_val;
	logic [7:0]  slot_wdata;
	logic [7:0]  rd_byte;
	uartrs_pkg::uartrs_sel_t wr_sel;
	uartrs_pkg::uartrs_sel_t rd_sel;

	// register selection from index and gating bits
	function automatic uartrs_pkg::uartrs_sel_t sel_of(input logic [3:0] idx, input logic wr,
		input logic dl, input logic bf, input logic tcr_en);
		uartrs_pkg::uartrs_sel_t s;
		s.kind = uartrs_pkg::K_NONE;
		s.slot = uartrs_pkg::SL_IER;
		case (idx)
			uartrs_pkg::IDX_DATA: begin
				// RULE_09 divisor gate
				if (dl) begin
					s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_DIV_LO};
				end else begin
					// RULE_01 shared data index
					s.kind = wr ? uartrs_pkg::K_THR : uartrs_pkg::K_RHR;
				end
			end
			uartrs_pkg::IDX_IER: begin
				// RULE_03 read/write store
				s = '{uartrs_pkg::K_STORE, dl ? uartrs_pkg::SL_DIV_HI : uartrs_pkg::SL_IER};
			end
			uartrs_pkg::IDX_IIR_FCR: begin
				// RULE_10 special set
				if (bf) begin
					s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_EFR};
				end else begin
					// RULE_02 split read/write
					s.kind = wr ? uartrs_pkg::K_FCR : uartrs_pkg::K_IIR;
				end
			end
			uartrs_pkg::IDX_LCR: s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_LCR};
			uartrs_pkg::IDX_MCR: s = '{uartrs_pkg::K_STORE, bf ? uartrs_pkg::SL_RES1 : uartrs_pkg::SL_MCR};
			uartrs_pkg::IDX_LSR: begin
				if (bf) begin
					s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_RES2};
				end else if (!wr) begin
					s.kind = uartrs_pkg::K_LSR;
				end
			end
			uartrs_pkg::IDX_MSR: begin
				// RULE_08 halt/resume gate
				if (bf) begin
					s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_PAU1};
				end else if (tcr_en) begin
					s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_TCR};
				end else if (!wr) begin
					s.kind = uartrs_pkg::K_MSR;
				end
			end
			uartrs_pkg::IDX_SPR: begin
				if (bf) begin
					s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_PAU2};
				end else begin
					s = '{uartrs_pkg::K_STORE, tcr_en ? uartrs_pkg::SL_TLR : uartrs_pkg::SL_SPR};
				end
			end
			// RULE_04 read-only levels
			uartrs_pkg::IDX_TX_FIFO_FILL_REG: s.kind = wr ? uartrs_pkg::K_NONE : uartrs_pkg::K_TX_FIFO_FILL_REG;
			uartrs_pkg::IDX_RX_FIFO_FILL_REG: s.kind = wr ? uartrs_pkg::K_NONE : uartrs_pkg::K_RX_FIFO_FILL_REG;
			// RULE_06 gpio stores
			uartrs_pkg::IDX_GPIO_DIR: begin
				if (uartrs_pkg::GPIO_PRESENT) begin
					s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_GPIO_DIR};
				end
			end
			// RULE_05 pin state read only
			uartrs_pkg::IDX_GPIO_ST: begin
				if (uartrs_pkg::GPIO_PRESENT && !wr) begin
					s.kind = uartrs_pkg::K_GPIO;
				end
			end
			uartrs_pkg::IDX_GPIO_IRQ: begin
				if (uartrs_pkg::GPIO_PRESENT) begin
					s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_GPIO_IRQ};
				end
			end
			uartrs_pkg::IDX_GPIO_CTL: begin
				if (uartrs_pkg::GPIO_PRESENT) begin
					s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_GPIO_CTL};
				end
			end
			uartrs_pkg::IDX_EXTRA: s = '{uartrs_pkg::K_STORE, uartrs_pkg::SL_EXTRA};
			default: s.kind = uartrs_pkg::K_NONE;
		endcase
		return s;
	endfunction

	// gating bits
	assign lcr_dl = store_q[uartrs_pkg::SL_LCR][uartrs_pkg::LCR_DL_BIT];
	// RULE_10 whole-byte match
	assign lcr_bf = (store_q[uartrs_pkg::SL_LCR] == uartrs_pkg::LCR_SPECIAL);
	// RULE_12 enhanced unlock
	assign enh_on = store_q[uartrs_pkg::SL_EFR][uartrs_pkg::EFR_ENH_BIT];
	// RULE_08 both enables
	assign tcr_on = enh_on && store_q[uartrs_pkg::SL_MCR][uartrs_pkg::MCR_TCR_BIT];

	// write channel: both halves held until the response is accepted
	assign wr_do       = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_unmapped = (aw_addr_reg[7:6] != 2'h0);
	assign wr_sel      = sel_of(aw_addr_reg[5:2], 1'b1, lcr_dl, lcr_bf, tcr_on);

	// RULE_07 prescaler bit locked
	assign mcr_wr_val = enh_on ? wdata_reg
		: {store_q[uartrs_pkg::SL_MCR][uartrs_pkg::MCR_PRESC_BIT], wdata_reg[6:0]};
	assign slot_wdata = (wr_sel.slot == uartrs_pkg::SL_MCR) ? mcr_wr_val : wdata_reg;

	genvar gi;
	generate
		for (gi = 0; gi < uartrs_pkg::NUM_SLOTS; gi++) begin : g_slot
			logic slot_we;
			// RULE_14 only mapped store writes
			assign slot_we = wr_do && wstrb0_reg && !wr_unmapped
				&& (wr_sel.kind == uartrs_pkg::K_STORE) && (wr_sel.slot == uartrs_pkg::uartrs_slot_t'(gi));
			uartrs_byte_reg #(
				.RESET_VAL(uartrs_pkg::RST_BYTE)
			) u_byte (
				.clk_sys  (clk_sys),
				.reset_n  (reset_n),
				.wr_en    (slot_we),
				.wr_data  (slot_wdata),
				.value_reg(store_q[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= uartrs_pkg::RESP_OKAY;
			aw_addr_reg   <= 8'h00;
			wdata_reg     <= 8'h00;
			wstrb0_reg    <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_reg    <= s_axi_wdata[7:0];
				wstrb0_reg   <= s_axi_wstrb[0];
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_unmapped ? uartrs_pkg::RESP_SLVERR : uartrs_pkg::RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// transmit and fifo-control strobes, one cycle each
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_load_reg        <= 1'b0;
			tx_data_reg        <= 8'h00;
			fifo_ctrl_load_reg <= 1'b0;
			fifo_ctrl_data_reg <= 8'h00;
		end else begin
			// RULE_01 transmit load
			tx_load_reg        <= wr_do && wstrb0_reg && !wr_unmapped && (wr_sel.kind == uartrs_pkg::K_THR);
			// RULE_02 fifo control load
			fifo_ctrl_load_reg <= wr_do && wstrb0_reg && !wr_unmapped && (wr_sel.kind == uartrs_pkg::K_FCR);
			if (wr_do && wstrb0_reg && !wr_unmapped && wr_sel.kind == uartrs_pkg::K_THR) begin
				tx_data_reg <= wdata_reg;
			end
			if (wr_do && wstrb0_reg && !wr_unmapped && wr_sel.kind == uartrs_pkg::K_FCR) begin
				fifo_ctrl_data_reg <= wdata_reg;
			end
		end
	end

	// pins come from outside the clock domain
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			gpio_meta_reg <= 8'h00;
			gpio_sync_reg <= 8'h00;
		end else begin
			gpio_meta_reg <= gpio_pins;
			gpio_sync_reg <= gpio_meta_reg;
		end
	end

	// read channel: address decoded at the handshake, data one cycle later
	assign rd_take     = s_axi_arvalid && s_axi_arready;
	assign rd_unmapped = (s_axi_araddr[7:6] != 2'h0);
	assign rd_sel      = sel_of(s_axi_araddr[5:2], 1'b0, lcr_dl, lcr_bf, tcr_on);

	always_comb begin
		rd_byte = 8'h00;
		case (rd_sel.kind)
			uartrs_pkg::K_STORE: rd_byte = store_q[rd_sel.slot];
			uartrs_pkg::K_RHR:   rd_byte = uart_status.rx_holding;
			uartrs_pkg::K_IIR:   rd_byte = uart_status.irq_ident;
			uartrs_pkg::K_LSR:   rd_byte = uart_status.line_status;
			uartrs_pkg::K_MSR:   rd_byte = uart_status.modem_status;
			uartrs_pkg::K_TX_FIFO_FILL_REG: rd_byte = uart_status.tx_fill;
			uartrs_pkg::K_RX_FIFO_FILL_REG: rd_byte = uart_status.rx_fill;
			uartrs_pkg::K_GPIO:  rd_byte = gpio_sync_reg;
			default:             rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready      <= 1'b1;
			s_axi_rvalid       <= 1'b0;
			s_axi_rdata        <= 32'h0000_0000;
			s_axi_rresp        <= uartrs_pkg::RESP_OKAY;
			rx_pop_reg         <= 1'b0;
			irq_ident_read_reg <= 1'b0;
		end else begin
			// RULE_01 receive byte consumed
			rx_pop_reg         <= rd_take && !rd_unmapped && (rd_sel.kind == uartrs_pkg::K_RHR);
			irq_ident_read_reg <= rd_take && !rd_unmapped && (rd_sel.kind == uartrs_pkg::K_IIR);
			if (rd_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_unmapped ? 32'h0000_0000 : {24'h00_0000, rd_byte};
				s_axi_rresp   <= rd_unmapped ? uartrs_pkg::RESP_SLVERR : uartrs_pkg::RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// RULE_13 divisor byte order
	assign uart_config = '{
		irq_enable:       store_q[uartrs_pkg::SL_IER],
		line_control:     store_q[uartrs_pkg::SL_LCR],
		modem_control:    store_q[uartrs_pkg::SL_MCR],
		scratch:          store_q[uartrs_pkg::SL_SPR],
		flow_halt_resume: store_q[uartrs_pkg::SL_TCR],
		trigger_level:    store_q[uartrs_pkg::SL_TLR],
		gpio_direction:   store_q[uartrs_pkg::SL_GPIO_DIR],
		gpio_irq_enable:  store_q[uartrs_pkg::SL_GPIO_IRQ],
		gpio_control:     store_q[uartrs_pkg::SL_GPIO_CTL],
		extra_features:   store_q[uartrs_pkg::SL_EXTRA],
		divisor:          {store_q[uartrs_pkg::SL_DIV_HI], store_q[uartrs_pkg::SL_DIV_LO]},
		enhanced_feature: store_q[uartrs_pkg::SL_EFR],
		resume_char_one:  store_q[uartrs_pkg::SL_RES1],
		resume_char_two:  store_q[uartrs_pkg::SL_RES2],
		pause_char_one:   store_q[uartrs_pkg::SL_PAU1],
		pause_char_two:   store_q[uartrs_pkg::SL_PAU2]
	};

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	AST_THR_LOAD: assert property (wr_do && wstrb0_reg && !wr_unmapped && aw_addr_reg[5:2] == 4'h0 && !lcr_dl // RULE_01
		|=> tx_load_reg && tx_data_reg == $past(wdata_reg) && !fifo_ctrl_load_reg)
		else $error("transmit load missing after data write");
	AST_RHR_POP: assert property (rd_take && !rd_unmapped && s_axi_araddr[5:2] == 4'h0 && !lcr_dl // RULE_01
		|=> rx_pop_reg && s_axi_rvalid && s_axi_rdata[7:0] == $past(uart_status.rx_holding))
		else $error("receive read did not pop or return holding byte");
	AST_FCR_LOAD: assert property (wr_do && wstrb0_reg && !wr_unmapped && aw_addr_reg[5:2] == 4'h2 && !lcr_bf // RULE_02
		|=> fifo_ctrl_load_reg ##1 !fifo_ctrl_load_reg)
		else $error("fifo control strobe wrong");
	AST_RO_IGNORE: assert property (wr_do && wr_sel.kind != uartrs_pkg::K_STORE // RULE_14
		|=> $stable(uart_config))
		else $error("write to read-only or locked register changed state");
	AST_PRESC_LOCK: assert property (!enh_on |=> // RULE_07
		uart_config.modem_control[7] == $past(uart_config.modem_control[7]))
		else $error("prescaler bit changed while locked");
	AST_TCR_GATE: assert property (!tcr_on // RULE_08
		|=> $stable(uart_config.flow_halt_resume) && $stable(uart_config.trigger_level))
		else $error("halt/resume or trigger level written while disabled");
	AST_DIV_GATE: assert property (!lcr_dl |=> $stable(uart_config.divisor)) // RULE_09
		else $error("divisor changed while latch closed");
	AST_SPECIAL_GATE: assert property (!lcr_bf // RULE_10
		|=> $stable(uart_config.enhanced_feature) && $stable(uart_config.pause_char_two))
		else $error("special register changed outside special mode");
	AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer not one cycle after address");
	AST_LCR_READBACK: assert property (wr_do && wstrb0_reg && !wr_unmapped && aw_addr_reg[5:2] == 4'h3 // RULE_03
		|=> uart_config.line_control == $past(wdata_reg))
		else $error("line control did not take written value");

endmodule

/* uartrs_host.sv */
`timescale 1ns/1ps
module uartrs_host (
	input  wire logic        clk_sys,
	output logic      [7:0]  awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic      [31:0] wdata,
	output logic      [3:0]  wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic        bvalid,
	input  wire logic [1:0]  bresp,
	output logic             bready,
	output logic      [7:0]  araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic        rvalid,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	output logic             rready
);
	// byte strobes of the next write, set by the bench
	logic [3:0] strb;

	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// each channel drops at its own handshake; stale payload is inverted so it cannot pass by luck
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h000000, d};
		wstrb <= strb;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (pa && awready) begin
				pa = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (pw && wready) begin
				pw = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~{24'h000000, d};
			end
		end while (!(bvalid && !pa && !pw));
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys); while (!arready);
		arvalid <= 1'b0;
		araddr <= ~a;
		do @(posedge clk_sys); while (!rvalid);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

/* test_uart_register_select_decoder.sv */
`timescale 1ns/1ps
module test_uart_register_select_decoder;
	logic                     clk_sys;
	logic                     reset_n;
	logic [7:0]               awaddr, araddr, pins, txd, fcd, v;
	logic                     awvalid, awready, wvalid, wready, bvalid, bready;
	logic                     arvalid, arready, rvalid, rready, txl, fcl, pop, iir_rd;
	logic [31:0]              wdata, rdata;
	logic [3:0]               wstrb;
	logic [1:0]               bresp, rresp, resp;
	logic [15:0]              dv;
	uartrs_pkg::uartrs_stat_t stat;
	uartrs_pkg::uartrs_cfg_t  cfg;
	logic [3:0]               rwi[7] = '{4'h1, 4'h3, 4'h7, 4'hA, 4'hC, 4'hE, 4'hF};
	logic [3:0]               roi[5] = '{4'h5, 4'h6, 4'h8, 4'h9, 4'hB};
	logic [15:0]              divs[3];
	int                       err_total, n_tests;
	int                       cyc = 0;
	int                       n_txl = 0, n_fcl = 0, n_pop = 0, n_iir = 0;

	uartrs_regsel dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.uart_status(stat), .gpio_pins(pins), .uart_config(cfg), .tx_data_reg(txd), .tx_load_reg(txl),
		.fifo_ctrl_data_reg(fcd), .fifo_ctrl_load_reg(fcl), .rx_pop_reg(pop), .irq_ident_read_reg(iir_rd));

	uartrs_host host (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
		.bresp(bresp), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic close_out();
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// a hung handshake ends here
	// one-cycle strobes are counted here, read back a few transfers later
	always @(posedge clk_sys) begin
		cyc++;
		if (txl === 1'b1)
			n_txl++;
		if (fcl === 1'b1)
			n_fcl++;
		if (pop === 1'b1)
			n_pop++;
		if (iir_rd === 1'b1)
			n_iir++;
		if (cyc == 5000) begin
			err_total++;
			close_out();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic put(input logic [3:0] i, input logic [7:0] d);
		host.wr({2'b00, i, 2'b00}, d, resp);
	endtask

	task automatic get(input logic [3:0] i, output logic [7:0] d);
		host.rd({2'b00, i, 2'b00}, d, resp);
	endtask

	task automatic rw(input logic [3:0] i, input logic [7:0] d, input logic [7:0] e);
		logic [7:0] q;
		put(i, d);
		get(i, q);
		check(q, e);
	endtask

	// prescaler bit keeps its old value unless the enhanced bit is set
	function automatic logic [7:0] mcr_exp(logic [7:0] old, logic [7:0] d, logic enh);
		return enh ? d : {old[7], d[6:0]};
	endfunction

	initial begin
		reset_n = 1'b0;
		stat = '0;
		pins = 8'h00;
		err_total = 0;
		n_tests = 0;
		host.strb = 4'hF;
		divs = '{uartrs_pkg::DIV_9600, uartrs_pkg::DIV_19200, uartrs_pkg::DIV_38400};
		void'($urandom(95));
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		stat <= 48'({$urandom, $urandom});
		pins <= 8'($urandom);
		get(4'h1, v);
		check(v, 8'h00);
		repeat (3) foreach (rwi[k]) begin
			v = 8'($urandom);
			// line control kept out of latch mode here
			if (rwi[k] == 4'h3)
				v[7] = 1'b0;
			rw(rwi[k], v, v);
		end
		rw(4'h7, 8'h5A, 8'h5A);
		check(cfg.scratch, 8'h5A);
		rw(4'h1, 8'h0F, 8'h0F);
		put(4'h3, 8'h03);
		foreach (roi[k])
			put(roi[k], 8'hFF);
		get(4'h5, v);
		check(v, stat.line_status);
		get(4'h6, v);
		check(v, stat.modem_status);
		get(4'h8, v);
		check(v, stat.tx_fill);
		get(4'h9, v);
		check(v, stat.rx_fill);
		get(4'hB, v);
		check(v, pins);
		put(4'h0, 8'hC3);
		check(txd, 8'hC3);
		get(4'h0, v);
		check(v, stat.rx_holding);
		put(4'h2, 8'h81);
		check(fcd, 8'h81);
		get(4'h2, v);
		check(v, stat.irq_ident);
		put(4'h4, 8'h84);
		check(8'(n_txl), 8'h01);
		check(8'(n_pop), 8'h01);
		check(8'(n_fcl), 8'h01);
		check(8'(n_iir), 8'h01);
		get(4'h4, v);
		check(v, mcr_exp(8'h00, 8'h84, 1'b0));
		put(4'h6, 8'hEE);
		get(4'h6, v);
		check(v, stat.modem_status);
		put(4'h3, uartrs_pkg::LCR_SPECIAL);
		rw(4'h2, 8'h10, 8'h10);
		for (int i = 4; i < 8; i++) begin
			v = 8'($urandom);
			rw(i[3:0], v, v);
		end
		put(4'h3, 8'h03);
		get(4'h4, v);
		check(v, 8'h04);
		put(4'h4, 8'h84);
		get(4'h4, v);
		check(v, mcr_exp(8'h04, 8'h84, 1'b1));
		v = 8'($urandom);
		rw(4'h6, v, v);
		check(cfg.flow_halt_resume, v);
		rw(4'h7, ~v, ~v);
		put(4'h4, 8'h80);
		get(4'h6, v);
		check(v, stat.modem_status);
		get(4'h7, v);
		check(v, 8'h5A);
		// low byte strobe clear: the write is answered but dropped
		host.strb = 4'hE;
		put(4'h7, 8'hA5);
		host.strb = 4'hF;
		check({6'h00, resp}, {6'h00, uartrs_pkg::RESP_OKAY});
		get(4'h7, v);
		check(v, 8'h5A);
		put(4'h3, 8'h80);
		// host programs the 3.072 MHz divisors, low byte first
		foreach (divs[k]) begin
			dv = divs[k];
			put(4'h0, dv[7:0]);
			put(4'h1, dv[15:8]);
			check(cfg.divisor[7:0], dv[7:0]);
			check(cfg.divisor[15:8], dv[15:8]);
			get(4'h0, v);
			check(v, dv[7:0]);
		end
		put(4'h3, 8'h03);
		put(4'h0, 8'h33);
		check(cfg.divisor[7:0], dv[7:0]);
		get(4'h1, v);
		check(v, 8'h0F);
		host.wr(8'h40, 8'h55, resp);
		check({6'h00, resp}, {6'h00, uartrs_pkg::RESP_SLVERR});
		host.rd(8'hC4, v, resp);
		check({6'h00, resp}, {6'h00, uartrs_pkg::RESP_SLVERR});
		check(cfg.line_control, 8'h03);
		check(txd, 8'h33);
		check(8'(n_txl), 8'h02);
		check(8'(n_fcl), 8'h01);
		check(8'(n_pop), 8'h01);
		reset_n <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		get(4'h3, v);
		check(v, 8'h00);
		close_out();
	end
endmodule
